// ===== design/ppcs_ctrl_pkg.sv
`default_nettype none
package ppcs_ctrl_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int AXI_ADDR_W = 12;
  localparam int AXI_DATA_W = 32;
  localparam int REG_W      = 8;

  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CODING_CTRL = 8'h05;
  localparam logic [7:0] IDX_ADV_UPPER   = 8'h06;
  localparam logic [7:0] IDX_ADV_LOWER   = 8'h07;
  localparam logic [7:0] IDX_NP_LOWER    = 8'h08;
  localparam logic [7:0] IDX_NP_UPPER    = 8'h09;
  localparam logic [7:0] IDX_IRQ_ENABLE  = 8'h0a;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'h8a;
  localparam logic [7:0] IDX_IRQ_CLEAR   = 8'h8b;

  // ---------------------------------------------------------------
  // coding control field positions
  // ---------------------------------------------------------------
  localparam int CTL_ALIGN_LOCK  = 0;
  localparam int CTL_TX_SCR_DIS  = 1;
  localparam int CTL_RX_DSCR_DIS = 2;
  localparam int CTL_AN_RESTART  = 4;
  localparam int CTL_AN_ENABLE   = 5;
  localparam int CTL_ENC_BYPASS  = 6;
  localparam int CTL_DEC_BYPASS  = 7;

  // ---------------------------------------------------------------
  // interrupt field positions, shared by enable, status and clear
  // ---------------------------------------------------------------
  localparam int IRQ_AN_RESOLVE  = 2;
  localparam int IRQ_AN_COMPLETE = 3;
  localparam int IRQ_AN_PAGE_RX  = 4;
  localparam int IRQ_NP_LOADED   = 5;
  localparam int IRQ_CTC_UNDER   = 6;
  localparam int IRQ_CTC_OVER    = 7;

  // implemented bits; reserved bits read as zero
  localparam logic [7:0] CTRL_IMPL_MASK = 8'hf7;
  localparam logic [7:0] IRQ_IMPL_MASK  = 8'hfc;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CODING_CTRL = 8'h00;
  localparam logic [7:0] RST_ADVERT      = 8'h00;
  localparam logic [7:0] RST_NEXT_PAGE   = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE  = 8'h00;
  localparam logic [7:0] RST_IRQ_STATUS  = 8'h00;

  // ---------------------------------------------------------------
  // bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  // event pulses, msb first so the struct lines up with status [7:2]
  typedef struct packed {
    logic ctc_overrun;
    logic ctc_underrun;
    logic np_loaded;
    logic an_page_rx;
    logic an_complete;
    logic an_resolve;
  } ppcs_evt_type;

  typedef struct packed {
    logic        dec_bypass;
    logic        enc_bypass;
    logic        an_enable;
    logic        an_restart;
    logic        rx_descr_dis;
    logic        tx_scr_dis;
    logic        align_lock;
    logic [15:0] an_advert;
    logic [15:0] an_next_page;
  } ppcs_ctrl_type;

endpackage
`default_nettype wire

// ===== design/ppcs_ctrl_regs.sv
// Operation
// R01: alignment locks only on a one written after a zero; zero unlocks.
// R02: control bit 1 set disables the transmit scrambler.
// R03: control bit 2 set disables the receive descrambler.
// R04: bit 5 enables autonegotiation; bit 4 restarts it while set.
// R05: control bit 6 set bypasses the transmit 8b/10b encoder.
// R06: control bit 7 set bypasses the receive 8b/10b decoder.
// R07: advertisement value is upper byte 0x06, lower byte 0x07.
// R08: next-page value is lower byte 0x08, upper byte 0x09.
// R09: enable bit 2 gates the resolve-priority event, status bit 2.
// R10: enable bit 3 gates autonegotiation complete, status bit 3.
// R11: enable bit 4 gates page received, status bit 4.
// R12: enable bit 5 gates next page loaded, status bit 5.
// R13: enable bit 6 gates clock tolerance fifo underrun, status bit 6.
// R14: enable bit 7 gates clock tolerance fifo overrun, status bit 7.
// R15: interrupt is high only while a set flag has its enable set; irq here follows an enable write one cycle late.
// R16: all control and enable registers reset to zero.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module ppcs_ctrl_regs
  import ppcs_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // write address channel
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output var  logic                  s_axi_awready,
  // write data channel
  input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output var  logic                  s_axi_wready,
  // write response channel
  output var  logic [1:0]            s_axi_bresp,
  output var  logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // read address channel
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output var  logic                  s_axi_arready,
  // read data channel
  output var  logic [AXI_DATA_W-1:0] s_axi_rdata,
  output var  logic [1:0]            s_axi_rresp,
  output var  logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // pcs events, one-cycle pulses
  input  wire ppcs_evt_type          pcs_evt,
  // pcs controls
  output var  ppcs_ctrl_type         pcs_ctrl,
  // channel interrupt
  output var  logic                  irq
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // upper address bits must be zero, low two bits are ignored
  function automatic logic [8:0] decode(input logic [AXI_ADDR_W-1:0] a);
    decode = {(a[AXI_ADDR_W-1:10] == '0), a[9:2]};
  endfunction

  function automatic logic hit(input logic [8:0] d, input logic [7:0] idx);
    hit = d[8] && (d[7:0] == idx);
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]            ctrl_r;
  logic [7:0]            adv_hi_r;
  logic [7:0]            adv_lo_r;
  logic [7:0]            np_lo_r;
  logic [7:0]            np_hi_r;
  logic [7:0]            ien_r;
  logic [7:0]            sts_r;
  logic [7:0]            sts_nxt;
  logic                  lock_r;
  logic                  lock_nxt;

  logic                  awready_r;
  logic                  wready_r;
  logic [AXI_ADDR_W-1:0] awaddr_r;
  logic [7:0]            wdata_r;
  logic                  wstrb0_r;
  logic                  bvalid_r;
  logic [1:0]            bresp_r;
  logic                  arready_r;
  logic                  rvalid_r;
  logic [AXI_DATA_W-1:0] rdata_r;
  logic [1:0]            rresp_r;
  logic                  irq_r;

  // ---------------------------------------------------------------
  // write path
  // ---------------------------------------------------------------
  // address and data are parked independently; either may come first
  wire aw_take  = s_axi_awvalid && awready_r;
  wire w_take   = s_axi_wvalid && wready_r;
  wire do_write = !awready_r && !wready_r && !bvalid_r;
  wire b_done   = bvalid_r && s_axi_bready;

  wire [8:0] wdec = decode(awaddr_r);
  wire wr_en    = do_write && wstrb0_r;
  wire wr_ctrl  = wr_en && hit(wdec, IDX_CODING_CTRL);
  wire wr_advh  = wr_en && hit(wdec, IDX_ADV_UPPER);
  wire wr_advl  = wr_en && hit(wdec, IDX_ADV_LOWER);
  wire wr_npl   = wr_en && hit(wdec, IDX_NP_LOWER);
  wire wr_nph   = wr_en && hit(wdec, IDX_NP_UPPER);
  wire wr_ien   = wr_en && hit(wdec, IDX_IRQ_ENABLE);
  wire wr_clr   = wr_en && hit(wdec, IDX_IRQ_CLEAR);

  // status is read only, so a write to it is an error like a miss
  wire w_mapped = hit(wdec, IDX_CODING_CTRL) || hit(wdec, IDX_ADV_UPPER)
               || hit(wdec, IDX_ADV_LOWER)   || hit(wdec, IDX_NP_LOWER)
               || hit(wdec, IDX_NP_UPPER)    || hit(wdec, IDX_IRQ_ENABLE)
               || hit(wdec, IDX_IRQ_CLEAR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      awaddr_r  <= '0;
      wdata_r   <= 8'h00;
      wstrb0_r  <= 1'b0;
    end else begin
      if (aw_take) begin
        awready_r <= 1'b0;
        awaddr_r  <= s_axi_awaddr;
      end else if (do_write) begin
        awready_r <= 1'b1;
      end
      if (w_take) begin
        wready_r <= 1'b0;
        wdata_r  <= s_axi_wdata[REG_W-1:0];
        wstrb0_r <= s_axi_wstrb[0];
      end else if (do_write) begin
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (b_done) begin
      bvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control and value registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= RST_CODING_CTRL; // R16
      adv_hi_r <= RST_ADVERT; // R16
      adv_lo_r <= RST_ADVERT;
      np_lo_r  <= RST_NEXT_PAGE; // R16
      np_hi_r  <= RST_NEXT_PAGE;
      ien_r    <= RST_IRQ_ENABLE; // R16
    end else begin
      if (wr_ctrl) ctrl_r <= wdata_r & CTRL_IMPL_MASK; // R02 R03 R04 R05 R06
      if (wr_advh) adv_hi_r <= wdata_r; // R07
      if (wr_advl) adv_lo_r <= wdata_r; // R07
      if (wr_npl) np_lo_r <= wdata_r; // R08
      if (wr_nph) np_hi_r <= wdata_r; // R08
      if (wr_ien) ien_r <= wdata_r & IRQ_IMPL_MASK;
    end
  end

  // ---------------------------------------------------------------
  // alignment lock
  // ---------------------------------------------------------------
  // a one written over a stored one does not lock: the zero must come first
  wire lock_arm = !ctrl_r[CTL_ALIGN_LOCK] && wdata_r[CTL_ALIGN_LOCK];
  assign lock_nxt = !wr_ctrl ? lock_r
                  : (lock_arm || (lock_r && wdata_r[CTL_ALIGN_LOCK])); // R01

  always_ff @(posedge aclk) begin
    if (!aresetn) lock_r <= 1'b0;
    else          lock_r <= lock_nxt;
  end

  // ---------------------------------------------------------------
  // interrupt status, enable and request
  // ---------------------------------------------------------------
  // set wins over a clear in the same cycle so no event is lost
  wire [7:0] evt_bits = {pcs_evt, 2'b00}; // R09 R10 R11 R12 R13 R14
  wire [7:0] clr_bits = wr_clr ? (wdata_r & IRQ_IMPL_MASK) : 8'h00;
  assign sts_nxt = (sts_r & ~clr_bits) | evt_bits;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_r <= RST_IRQ_STATUS;
      irq_r <= 1'b0;
    end else begin
      sts_r <= sts_nxt;
      irq_r <= |(sts_nxt & ien_r); // R15
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  wire       ar_take = s_axi_arvalid && arready_r;
  wire       r_done  = rvalid_r && s_axi_rready;
  wire [8:0] rdec    = decode(s_axi_araddr);

  // clear register is write only and reads as zero
  wire [7:0] rd_byte =
      hit(rdec, IDX_CODING_CTRL) ? ctrl_r :
      hit(rdec, IDX_ADV_UPPER)   ? adv_hi_r :
      hit(rdec, IDX_ADV_LOWER)   ? adv_lo_r :
      hit(rdec, IDX_NP_LOWER)    ? np_lo_r :
      hit(rdec, IDX_NP_UPPER)    ? np_hi_r :
      hit(rdec, IDX_IRQ_ENABLE)  ? ien_r :
      hit(rdec, IDX_IRQ_STATUS)  ? sts_r : 8'h00;

  wire r_mapped = hit(rdec, IDX_CODING_CTRL) || hit(rdec, IDX_ADV_UPPER)
               || hit(rdec, IDX_ADV_LOWER)   || hit(rdec, IDX_NP_LOWER)
               || hit(rdec, IDX_NP_UPPER)    || hit(rdec, IDX_IRQ_ENABLE)
               || hit(rdec, IDX_IRQ_STATUS)  || hit(rdec, IDX_IRQ_CLEAR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= {{(AXI_DATA_W-REG_W){1'b0}}, rd_byte};
      rresp_r   <= r_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (r_done) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign irq           = irq_r;

  assign pcs_ctrl.align_lock   = lock_r; // R01
  assign pcs_ctrl.tx_scr_dis   = ctrl_r[CTL_TX_SCR_DIS]; // R02
  assign pcs_ctrl.rx_descr_dis = ctrl_r[CTL_RX_DSCR_DIS]; // R03
  assign pcs_ctrl.an_restart   = ctrl_r[CTL_AN_RESTART]; // R04
  assign pcs_ctrl.an_enable    = ctrl_r[CTL_AN_ENABLE]; // R04
  assign pcs_ctrl.enc_bypass   = ctrl_r[CTL_ENC_BYPASS]; // R05
  assign pcs_ctrl.dec_bypass   = ctrl_r[CTL_DEC_BYPASS]; // R06
  assign pcs_ctrl.an_advert    = {adv_hi_r, adv_lo_r}; // R07
  assign pcs_ctrl.an_next_page = {np_hi_r, np_lo_r}; // R08

endmodule // ppcs_ctrl_regs
`default_nettype wire

// ===== verification/ppcs_ctrl_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module ppcs_ctrl_regs_props
  import ppcs_ctrl_pkg::*;
(
  // clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // bus
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  // pcs side
  input wire ppcs_evt_type          pcs_evt,
  input wire ppcs_ctrl_type         pcs_ctrl,
  input wire logic                  irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // cycles since the last event or write beat; saturates
  logic [2:0] gap_r;
  logic [2:0] gap_nxt;
  logic       cause;
  assign cause   = (pcs_evt != '0) || (s_axi_wvalid && s_axi_wready);
  assign gap_nxt = cause ? 3'h0 : ((gap_r == 3'h7) ? gap_r : gap_r + 3'h1);
  always_ff @(posedge aclk) begin
    gap_r <= !aresetn ? 3'h7 : gap_nxt;
  end

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_busy_then_resp;
    ##1 (!s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid;
  endsequence

  property p_wr_answer;
    s_wr_taken |-> s_wr_busy_then_resp;
  endproperty
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_rdata_lane;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  property p_rst;
    $rose(aresetn) |-> pcs_ctrl == '0 && !irq && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  property p_irq_cause;
    $rose(irq) |-> gap_r < 3'h4;
  endproperty
  property p_ctrl_cause;
    !$stable(pcs_ctrl) |-> gap_r < 3'h3;
  endproperty

  a_wr_answer:  assert property (p_wr_answer) else $error("write answer late");
  a_rd_answer:  assert property (p_rd_answer) else $error("read answer late");
  a_b_hold:     assert property (p_b_hold) else $error("write response dropped");
  a_r_hold:     assert property (p_r_hold) else $error("read data dropped");
  a_rdata_lane: assert property (p_rdata_lane) else $error("read upper lanes set");
  a_rst:        assert property (p_rst) else $error("reset state wrong");
  a_irq_cause:  assert property (p_irq_cause) else $error("irq without cause");
  a_ctrl_cause: assert property (p_ctrl_cause) else $error("ctrl moved unasked");
endmodule // ppcs_ctrl_regs_props
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ppcs_ctrl_pkg::*;
  logic                  aclk;
  logic                  aresetn;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic [AXI_DATA_W-1:0] wdata, rdata;
  logic [1:0]            bresp, rresp;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready, irq;
  ppcs_evt_type          evt;
  ppcs_ctrl_type         ctrl;
  int                    mismatches, tests_run, cycles;

  ppcs_ctrl_regs u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pcs_evt(evt), .pcs_ctrl(ctrl), .irq(irq)
  );

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(64'(bresp), 64'(r));
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(64'(rdata), 64'(d));
    chk(64'(rresp), 64'(r));
  endtask
  task automatic pulse(input int i);
    @(posedge aclk);
    evt <= ppcs_evt_type'(6'h01 << i);
    @(posedge aclk);
    evt <= '0;
    repeat (3) @(posedge aclk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // hang guard, a few hundred cycles are expected
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    {aresetn, awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready, evt, mismatches, tests_run, cycles} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk(64'(ctrl), 64'h0);
    for (int i = 5; i <= 10; i++) rd(ad(8'(i)), 8'h00, RESP_OKAY);
    for (int b = 1; b <= 7; b++) begin
      wr(ad(IDX_CODING_CTRL), 8'(1 << b), RESP_OKAY);
      chk(64'(ctrl[38:32]), (b == 3) ? 64'h0 : 64'(1 << ((b > 3) ? b - 1 : b)));
      rd(ad(IDX_CODING_CTRL), (b == 3) ? 8'h00 : 8'(1 << b), RESP_OKAY);
    end
    wr(ad(IDX_CODING_CTRL), 8'h01, RESP_OKAY);
    chk(64'(ctrl.align_lock), 64'h1);
    wr(ad(IDX_CODING_CTRL), 8'h01, RESP_OKAY);
    chk(64'(ctrl.align_lock), 64'h1);
    wr(ad(IDX_CODING_CTRL), 8'h00, RESP_OKAY);
    chk(64'(ctrl.align_lock), 64'h0);
    wr(ad(IDX_ADV_UPPER), 8'ha5, RESP_OKAY);
    wr(ad(IDX_ADV_LOWER), 8'h3c, RESP_OKAY);
    wr(ad(IDX_NP_LOWER), 8'h12, RESP_OKAY);
    wr(ad(IDX_NP_UPPER), 8'h34, RESP_OKAY);
    chk(64'(ctrl.an_advert), 64'ha53c);
    chk(64'(ctrl.an_next_page), 64'h3412);
    // stray and read-only places must not disturb the controls
    rd(12'h010, 8'h00, RESP_SLVERR);
    wr(12'h414, 8'hff, RESP_SLVERR);
    wr(ad(IDX_IRQ_STATUS), 8'hff, RESP_SLVERR);
    rd(ad(IDX_IRQ_CLEAR), 8'h00, RESP_OKAY);
    chk(64'(ctrl[38:32]), 64'h0);
    wr(ad(IDX_IRQ_ENABLE), 8'hff, RESP_OKAY);
    rd(ad(IDX_IRQ_ENABLE), 8'hfc, RESP_OKAY);
    for (int b = 2; b <= 7; b++) begin
      wr(ad(IDX_IRQ_ENABLE), 8'hfc ^ 8'(1 << b), RESP_OKAY);
      pulse(b - 2);
      chk(64'(irq), 64'h0);
      rd(ad(IDX_IRQ_STATUS), 8'(1 << b), RESP_OKAY);
      wr(ad(IDX_IRQ_ENABLE), 8'(1 << b), RESP_OKAY);
      repeat (2) @(posedge aclk);
      #1;
      chk(64'(irq), 64'h1);
      wr(ad(IDX_IRQ_CLEAR), 8'(1 << b), RESP_OKAY);
      repeat (2) @(posedge aclk);
      #1;
      chk(64'(irq), 64'h0);
      rd(ad(IDX_IRQ_STATUS), 8'h00, RESP_OKAY);
    end
    tally_and_finish();
  end
endmodule // tb

bind ppcs_ctrl_regs ppcs_ctrl_regs_props u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pcs_evt, .pcs_ctrl, .irq
);
`default_nettype wire
